/* dv/hpsr_line_model.sv */
// far-side transceiver model that resolves each data wire from both of its drivers
`timescale 1ns/1ps
module hpsr_line_model (
    input wire logic clk,
    input wire logic [7:0] pos_o,
    input wire logic [7:0] pos_oe,
    input wire logic [7:0] neg_o,
    input wire logic [7:0] neg_oe,
    output logic [7:0] pos_w,
    output logic [7:0] neg_w
);
    logic [7:0] far_pos = 8'h3c;
    logic [7:0] far_neg = 8'ha5;
    // undriven lines wander every cycle, so a stale value cannot pass for a real one
    always @(posedge clk) begin
        far_pos <= far_pos + 8'h4b;
        far_neg <= far_neg + 8'h95;
    end
    // an enabled design driver wins, otherwise the far transceiver owns the wire
    assign pos_w = (pos_oe & pos_o) | (~pos_oe & far_pos);
    assign neg_w = (neg_oe & neg_o) | (~neg_oe & far_neg);
endmodule : hpsr_line_model

/* dv/hpsr_top_tb.sv */
// self-checking bench: register access, pin exchange and port renumbering
`timescale 1ns/1ps
module hpsr_top_tb import hpsr_pkg::*;;
    logic CLK = 0, RST_B = 0, CE = 1;
    logic [11:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0;
    logic S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, PORT1_ENABLED, PORT2_ENABLED;
    logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 0, PORT1_LOGICAL, PORT2_LOGICAL;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [7:0] PHY_POS_OUT = 0, PHY_POS_OE = 0, PHY_NEG_OUT = 0, PHY_NEG_OE = 0;
    logic [7:0] PHY_POS_IN, PHY_NEG_IN, POSITIVE_LINE_PIN_I, NEGATIVE_LINE_PIN_I;
    logic [7:0] POSITIVE_LINE_PIN_O, POSITIVE_LINE_PIN_OE, NEGATIVE_LINE_PIN_O;
    logic [7:0] NEGATIVE_LINE_PIN_OE, smp_pos, smp_neg;
    logic [7:0] masks [5] = '{8'h00, 8'hff, 8'h01, 8'he0, 8'h1e};
    // contiguous numberings only, reserved codes included
    logic [7:0] maps [8] = '{8'h21, 8'h12, 8'h01, 8'h10, 8'h00, 8'h8f, 8'h81, 8'h1f};
    logic [3:0] strb = 4'h1;
    int err_count = 0, cmp_count = 0, cyc = 0;

    hpsr_top u_hpsr_top (.CLK, .RST_B, .CE, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
        .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
        .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .PHY_POS_OUT, .PHY_POS_OE, .PHY_NEG_OUT,
        .PHY_NEG_OE, .PHY_POS_IN, .PHY_NEG_IN, .POSITIVE_LINE_PIN_I, .POSITIVE_LINE_PIN_O,
        .POSITIVE_LINE_PIN_OE, .NEGATIVE_LINE_PIN_I, .NEGATIVE_LINE_PIN_O,
        .NEGATIVE_LINE_PIN_OE, .PORT1_LOGICAL, .PORT2_LOGICAL, .PORT1_ENABLED, .PORT2_ENABLED);
    hpsr_line_model u_hpsr_line_model (.clk(CLK), .pos_o(POSITIVE_LINE_PIN_O),
        .pos_oe(POSITIVE_LINE_PIN_OE), .neg_o(NEGATIVE_LINE_PIN_O),
        .neg_oe(NEGATIVE_LINE_PIN_OE), .pos_w(POSITIVE_LINE_PIN_I), .neg_w(NEGATIVE_LINE_PIN_I));

    // clock, plus wire levels as the design saw them at the last edge
    initial begin
        forever #25 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        smp_pos <= POSITIVE_LINE_PIN_I;
        smp_neg <= NEGATIVE_LINE_PIN_I;
    end
    // hang guard, far above the roughly six hundred and twenty cycles the run needs
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // master keeps each channel up until its own ready, bready until bvalid
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h0, d};
        S_AXI_WSTRB <= strb;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        S_AXI_BREADY <= 1'b0;
        chk({6'h0, S_AXI_BRESP}, {6'h0, er});
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        S_AXI_RREADY <= 1'b0;
        chk({6'h0, S_AXI_RRESP}, {6'h0, er});
        chk(S_AXI_RDATA[7:0], d);
        chk({7'h0, |S_AXI_RDATA[31:8]}, 8'h00);
    endtask : axi_rd

    // a set mask bit takes the other line, a clear one keeps its own
    function automatic logic [7:0] mux(input logic [7:0] s, input logic [7:0] a,
                                       input logic [7:0] b);
        return (s & b) | (~s & a);
    endfunction : mux
    function automatic logic [3:0] exp_num(input logic [3:0] f, input logic en,
                                           input logic [3:0] id);
        if (!en) return id;
        if (f > 4'h7) return 4'h0;
        return f;
    endfunction : exp_num
    // host view: enabled ports must fill 1..count with no gap
    function automatic logic host_view_ok(input logic [3:0] a, input logic [3:0] b);
        logic [3:0] lo, hi;
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        return (hi == 4'h0) || (lo == 4'h0 && hi == 4'h1) || (lo == 4'h1 && hi == 4'h2);
    endfunction : host_view_ok

    task automatic pin_case(input logic [7:0] m);
        axi_wr(HPSR_ADDR_SWAP, m, HPSR_RESP_OKAY);
        axi_rd(HPSR_ADDR_SWAP, m, HPSR_RESP_OKAY);
        repeat (6) begin
            @(posedge CLK);
            PHY_POS_OUT <= 8'($urandom);
            PHY_POS_OE <= 8'($urandom);
            PHY_NEG_OUT <= 8'($urandom);
            PHY_NEG_OE <= 8'($urandom);
            @(posedge CLK);
            #1;
            chk(POSITIVE_LINE_PIN_O, mux(m, PHY_POS_OUT, PHY_NEG_OUT));
            chk(POSITIVE_LINE_PIN_OE, mux(m, PHY_POS_OE, PHY_NEG_OE));
            chk(NEGATIVE_LINE_PIN_O, mux(m, PHY_NEG_OUT, PHY_POS_OUT));
            chk(NEGATIVE_LINE_PIN_OE, mux(m, PHY_NEG_OE, PHY_POS_OE));
            chk(PHY_POS_IN, mux(m, smp_pos, smp_neg));
            chk(PHY_NEG_IN, mux(m, smp_neg, smp_pos));
        end
    endtask : pin_case
    // numbering shows one edge after the write handshake
    task automatic map_case(input logic en, input logic [7:0] f);
        logic [3:0] e1, e2;
        e1 = exp_num(f[3:0], en, HPSR_ID_P1);
        e2 = exp_num(f[7:4], en, HPSR_ID_P2);
        axi_wr(HPSR_ADDR_CONFIG, {7'h0, en}, HPSR_RESP_OKAY);
        axi_wr(HPSR_ADDR_REMAP12, f, HPSR_RESP_OKAY);
        @(posedge CLK);
        #1;
        chk({4'h0, PORT1_LOGICAL}, {4'h0, e1});
        chk({4'h0, PORT2_LOGICAL}, {4'h0, e2});
        chk({6'h0, PORT1_ENABLED, PORT2_ENABLED}, {6'h0, e1 != 0, e2 != 0});
        chk({7'h0, host_view_ok(PORT1_LOGICAL, PORT2_LOGICAL)}, 8'h01);
        axi_rd(HPSR_ADDR_STATUS, {e2, e1}, HPSR_RESP_OKAY);
        axi_rd(HPSR_ADDR_REMAP12, f, HPSR_RESP_OKAY);
        axi_rd(HPSR_ADDR_CONFIG, {7'h0, en}, HPSR_RESP_OKAY);
    endtask : map_case
    // enable low freezes every flop, so the pins keep the last launched level
    task automatic hold_case(input logic [7:0] m);
        logic [7:0] held;
        axi_wr(HPSR_ADDR_SWAP, m, HPSR_RESP_OKAY);
        @(posedge CLK);
        PHY_POS_OUT <= 8'($urandom);
        @(posedge CLK);
        held = mux(m, PHY_POS_OUT, PHY_NEG_OUT);
        CE <= 1'b0;
        repeat (4) begin
            @(posedge CLK);
            PHY_POS_OUT <= 8'($urandom);
            #1;
            chk(POSITIVE_LINE_PIN_O, held);
        end
        @(posedge CLK);
        CE <= 1'b1;
        @(posedge CLK);
        #1;
        chk(POSITIVE_LINE_PIN_O, mux(m, PHY_POS_OUT, PHY_NEG_OUT));
    endtask : hold_case

    task end_sim;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // main sequence: reset values, refusals, then pin and numbering sweeps
    initial begin
        void'($urandom(32'hf82d));
        repeat (4) @(posedge CLK);
        RST_B <= 1'b1;
        axi_rd(HPSR_ADDR_SWAP, HPSR_RST_SWAP, HPSR_RESP_OKAY);
        axi_rd(HPSR_ADDR_REMAP12, HPSR_RST_REMAP12, HPSR_RESP_OKAY);
        axi_rd(HPSR_ADDR_CONFIG, {7'h0, HPSR_RST_RENUM}, HPSR_RESP_OKAY);
        chk({PORT2_LOGICAL, PORT1_LOGICAL}, {HPSR_ID_P2, HPSR_ID_P1});
        axi_wr(12'h004, 8'h5a, HPSR_RESP_SLVERR);
        axi_rd(12'h004, 8'h00, HPSR_RESP_SLVERR);
        axi_wr(HPSR_ADDR_STATUS, 8'h00, HPSR_RESP_OKAY);
        // a write with its low strobe clear must leave the register untouched
        strb = 4'h0;
        axi_wr(HPSR_ADDR_SWAP, 8'h5a, HPSR_RESP_OKAY);
        strb = 4'h1;
        axi_rd(HPSR_ADDR_SWAP, HPSR_RST_SWAP, HPSR_RESP_OKAY);
        foreach (masks[i]) pin_case(masks[i]);
        repeat (4) pin_case(8'($urandom));
        map_case(1'b0, 8'h00);
        map_case(1'b0, 8'h8f);
        foreach (maps[i]) map_case(1'b1, maps[i]);
        repeat (8) map_case(1'($urandom), maps[$urandom_range(7)]);
        hold_case(8'h5a);
        hold_case(8'($urandom));
        end_sim();
    end
endmodule : hpsr_top_tb

/* hdl/hpsr_pin_swap.sv */
// module: per-port exchange of positive and negative data pins
`timescale 1ns/1ps
module hpsr_pin_swap import hpsr_pkg::*; #(
    parameter int N = HPSR_NUM_PORTS
) (
    input wire logic [N-1:0] swap,
    input wire logic [N-1:0] phy_pos_out,
    input wire logic [N-1:0] phy_pos_oe,
    input wire logic [N-1:0] phy_neg_out,
    input wire logic [N-1:0] phy_neg_oe,
    input wire logic [N-1:0] pin_pos_in,
    input wire logic [N-1:0] pin_neg_in,
    output logic [N-1:0] pin_pos_out,
    output logic [N-1:0] pin_pos_oe,
    output logic [N-1:0] pin_neg_out,
    output logic [N-1:0] pin_neg_oe,
    output logic [N-1:0] phy_pos_in,
    output logic [N-1:0] phy_neg_in
);
    // refuse port counts that the mask layout cannot serve
    if (N < 1 || N > 16) begin : g_bad_n
        $error("hpsr_pin_swap: port count out of range");
    end

    // bit i of the mask steers port i; bit 0 is the upstream port
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (swap[i]) begin
                // exchanged: both drive and receive cross over
                pin_pos_out[i] = phy_neg_out[i];
                pin_pos_oe[i] = phy_neg_oe[i];
                pin_neg_out[i] = phy_pos_out[i];
                pin_neg_oe[i] = phy_pos_oe[i];
                phy_pos_in[i] = pin_neg_in[i];
                phy_neg_in[i] = pin_pos_in[i];
            end else begin
                // straight through
                pin_pos_out[i] = phy_pos_out[i];
                pin_pos_oe[i] = phy_pos_oe[i];
                pin_neg_out[i] = phy_neg_out[i];
                pin_neg_oe[i] = phy_neg_oe[i];
                phy_pos_in[i] = pin_pos_in[i];
                phy_neg_in[i] = pin_neg_in[i];
            end
        end
    end
endmodule : hpsr_pin_swap

/* hdl/hpsr_pkg.sv */
// package: register map, field layout and reset values of the port swap and remap block
package hpsr_pkg;
    localparam int HPSR_NUM_PORTS = 8;
    localparam int HPSR_ADDR_W = 12;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [9:0] HPSR_IDX_CONFIG = 10'h008;
    localparam logic [9:0] HPSR_IDX_SWAP = 10'h0fa;
    localparam logic [9:0] HPSR_IDX_REMAP12 = 10'h0fb;
    localparam logic [9:0] HPSR_IDX_STATUS = 10'h0fc;
    localparam logic [11:0] HPSR_ADDR_CONFIG = {HPSR_IDX_CONFIG, 2'h0};
    localparam logic [11:0] HPSR_ADDR_SWAP = {HPSR_IDX_SWAP, 2'h0};
    localparam logic [11:0] HPSR_ADDR_REMAP12 = {HPSR_IDX_REMAP12, 2'h0};
    localparam logic [11:0] HPSR_ADDR_STATUS = {HPSR_IDX_STATUS, 2'h0};
    // field positions
    localparam int HPSR_RENUM_EN_BIT = 0;
    localparam int HPSR_P1_LSB = 0;
    localparam int HPSR_P2_LSB = 4;
    localparam int HPSR_UP_SWAP_BIT = 0;
    // reset values
    localparam logic [7:0] HPSR_RST_SWAP = 8'h00;
    localparam logic [7:0] HPSR_RST_REMAP12 = 8'h21;
    localparam logic HPSR_RST_RENUM = 1'b0;
    // identity numbers used while renumbering is off
    localparam logic [3:0] HPSR_ID_P1 = 4'h1;
    localparam logic [3:0] HPSR_ID_P2 = 4'h2;
    localparam logic [1:0] HPSR_RESP_OKAY = 2'h0;
    localparam logic [1:0] HPSR_RESP_SLVERR = 2'h2;

    // logical number of one physical port; 0 means disabled
    function automatic logic [3:0] hpsr_logical(input logic [3:0] field, input logic renum,
                                                input logic [3:0] identity);
        if (!renum) begin
            return identity;
        end else if (field[3]) begin
            return 4'h0;           // reserved codes act as disabled
        end else begin
            return field;
        end
    endfunction : hpsr_logical
endpackage : hpsr_pkg

/* hdl/hpsr_top.sv */
// module: port swap and remap registers with an AXI4-Lite slave
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module hpsr_top import hpsr_pkg::*; #(
    parameter int ADDR_W = HPSR_ADDR_W
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [7:0] PHY_POS_OUT,
    input wire logic [7:0] PHY_POS_OE,
    input wire logic [7:0] PHY_NEG_OUT,
    input wire logic [7:0] PHY_NEG_OE,
    output logic [7:0] PHY_POS_IN,
    output logic [7:0] PHY_NEG_IN,
    input wire logic [7:0] POSITIVE_LINE_PIN_I,
    output logic [7:0] POSITIVE_LINE_PIN_O,
    output logic [7:0] POSITIVE_LINE_PIN_OE,
    input wire logic [7:0] NEGATIVE_LINE_PIN_I,
    output logic [7:0] NEGATIVE_LINE_PIN_O,
    output logic [7:0] NEGATIVE_LINE_PIN_OE,
    output logic [3:0] PORT1_LOGICAL,
    output logic [3:0] PORT2_LOGICAL,
    output logic PORT1_ENABLED,
    output logic PORT2_ENABLED
);
    // refuse address widths that cannot hold the register map
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
        $error("hpsr_top: address width must be 12 to 32 bits");
    end

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] swap;
        logic [7:0] remap;
        logic renum;
        logic [7:0] pos_o;
        logic [7:0] pos_oe;
        logic [7:0] neg_o;
        logic [7:0] neg_oe;
        logic [7:0] pos_i;
        logic [7:0] neg_i;
        logic [3:0] p1_log;
        logic [3:0] p2_log;
        logic p1_en;
        logic p2_en;
    } hpsr_state_s;

    localparam hpsr_state_s HPSR_RST_STATE = '{swap: HPSR_RST_SWAP, remap: HPSR_RST_REMAP12,
        renum: HPSR_RST_RENUM, p1_log: HPSR_ID_P1, p2_log: HPSR_ID_P2,
        p1_en: |HPSR_ID_P1, p2_en: |HPSR_ID_P2, default: '0};

    hpsr_state_s st;
    hpsr_state_s next_st;
    logic [7:0] sw_pos_o;
    logic [7:0] sw_pos_oe;
    logic [7:0] sw_neg_o;
    logic [7:0] sw_neg_oe;
    logic [7:0] sw_pos_i;
    logic [7:0] sw_neg_i;
    logic [11:0] wr_addr;
    logic [11:0] rd_addr;

    // only the low twelve bits decode; wider buses alias
    assign wr_addr = S_AXI_AWADDR[11:0];
    assign rd_addr = S_AXI_ARADDR[11:0];

    // pin exchange, steered by the live swap mask
    hpsr_pin_swap #(.N(HPSR_NUM_PORTS)) u_swap (
        .swap(st.swap),
        .phy_pos_out(PHY_POS_OUT),
        .phy_pos_oe(PHY_POS_OE),
        .phy_neg_out(PHY_NEG_OUT),
        .phy_neg_oe(PHY_NEG_OE),
        .pin_pos_in(POSITIVE_LINE_PIN_I),
        .pin_neg_in(NEGATIVE_LINE_PIN_I),
        .pin_pos_out(sw_pos_o),
        .pin_pos_oe(sw_pos_oe),
        .pin_neg_out(sw_neg_o),
        .pin_neg_oe(sw_neg_oe),
        .phy_pos_in(sw_pos_i),
        .phy_neg_in(sw_neg_i)
    );

    // next state: bus slave, register writes, registered pin and map outputs
    always_comb begin
        next_st = st;
        // write: both channels taken together, one cycle after both are valid
        next_st.awready = S_AXI_AWVALID && S_AXI_WVALID && !st.awready && !st.bvalid;
        next_st.wready = S_AXI_AWVALID && S_AXI_WVALID && !st.awready && !st.bvalid;
        if (st.bvalid && S_AXI_BREADY) begin
            next_st.bvalid = 1'b0;
        end
        if (st.awready) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = HPSR_RESP_OKAY;
            unique case (wr_addr)
                HPSR_ADDR_CONFIG: begin
                    if (S_AXI_WSTRB[0]) begin
                        next_st.renum = S_AXI_WDATA[HPSR_RENUM_EN_BIT];
                    end
                end
                HPSR_ADDR_SWAP: begin
                    if (S_AXI_WSTRB[0]) begin
                        next_st.swap = S_AXI_WDATA[7:0];
                    end
                end
                HPSR_ADDR_REMAP12: begin
                    if (S_AXI_WSTRB[0]) begin
                        next_st.remap = S_AXI_WDATA[7:0];
                    end
                end
                HPSR_ADDR_STATUS: ;  // read-only, write ignored
                default: next_st.bresp = HPSR_RESP_SLVERR;
            endcase
        end
        // read: address taken one cycle after valid, data the cycle after
        next_st.arready = S_AXI_ARVALID && !st.arready && !st.rvalid;
        if (st.rvalid && S_AXI_RREADY) begin
            next_st.rvalid = 1'b0;
        end
        if (st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = HPSR_RESP_OKAY;
            next_st.rdata = 32'h0;
            unique case (rd_addr)
                HPSR_ADDR_CONFIG: next_st.rdata[HPSR_RENUM_EN_BIT] = st.renum;
                HPSR_ADDR_SWAP: next_st.rdata[7:0] = st.swap;
                HPSR_ADDR_REMAP12: next_st.rdata[7:0] = st.remap;
                HPSR_ADDR_STATUS: next_st.rdata[7:0] = {st.p2_log, st.p1_log};
                default: next_st.rresp = HPSR_RESP_SLVERR;
            endcase
        end
        // pins registered so every output leaves a flop; costs one cycle of latency
        next_st.pos_o = sw_pos_o;
        next_st.pos_oe = sw_pos_oe;
        next_st.neg_o = sw_neg_o;
        next_st.neg_oe = sw_neg_oe;
        next_st.pos_i = sw_pos_i;
        next_st.neg_i = sw_neg_i;
        // logical numbers; host side numbering is left to the host
        next_st.p1_log = hpsr_logical(st.remap[HPSR_P1_LSB +: 4], st.renum, HPSR_ID_P1);
        next_st.p2_log = hpsr_logical(st.remap[HPSR_P2_LSB +: 4], st.renum, HPSR_ID_P2);
        // enables kept in their own flops so the outputs carry no gate after the register
        next_st.p1_en = |next_st.p1_log;
        next_st.p2_en = |next_st.p2_log;
    end

    // single state register; clock enable freezes everything
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st <= HPSR_RST_STATE;
        end else if (CE) begin
            st <= next_st;
        end
    end

    assign S_AXI_AWREADY = st.awready;
    assign S_AXI_WREADY = st.wready;
    assign S_AXI_BVALID = st.bvalid;
    assign S_AXI_BRESP = st.bresp;
    assign S_AXI_ARREADY = st.arready;
    assign S_AXI_RVALID = st.rvalid;
    assign S_AXI_RRESP = st.rresp;
    assign S_AXI_RDATA = st.rdata;
    assign POSITIVE_LINE_PIN_O = st.pos_o;
    assign POSITIVE_LINE_PIN_OE = st.pos_oe;
    assign NEGATIVE_LINE_PIN_O = st.neg_o;
    assign NEGATIVE_LINE_PIN_OE = st.neg_oe;
    assign PHY_POS_IN = st.pos_i;
    assign PHY_NEG_IN = st.neg_i;
    assign PORT1_LOGICAL = st.p1_log;
    assign PORT2_LOGICAL = st.p2_log;
    assign PORT1_ENABLED = st.p1_en;
    assign PORT2_ENABLED = st.p2_en;

    // checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_wr_taken;
        CE && S_AXI_AWVALID && S_AXI_AWREADY;
    endsequence
    sequence s_bresp_up;
        CE [*1] ##0 S_AXI_BVALID;
    endsequence

    a_pin_straight: assert property (CE && !st.swap[3] |=> POSITIVE_LINE_PIN_O[3] == $past(PHY_POS_OUT[3]) && NEGATIVE_LINE_PIN_O[3] == $past(PHY_NEG_OUT[3])) else $error("unswapped port not straight");
    a_pin_crossed: assert property (CE && st.swap[2] |=> POSITIVE_LINE_PIN_O[2] == $past(PHY_NEG_OUT[2]) && PHY_NEG_IN[2] == $past(POSITIVE_LINE_PIN_I[2])) else $error("swapped port not crossed");
    a_port_seven_swap: assert property (CE && st.swap[7] |=> NEGATIVE_LINE_PIN_OE[7] == $past(PHY_POS_OE[7])) else $error("port 7 not steered by bit 7");
    a_upstream_swap: assert property (CE && st.swap[HPSR_UP_SWAP_BIT] |=> POSITIVE_LINE_PIN_O[0] == $past(PHY_NEG_OUT[0])) else $error("upstream not steered by bit 0");
    a_port_four_swap: assert property (CE && st.swap[4] |=> PHY_POS_IN[4] == $past(NEGATIVE_LINE_PIN_I[4])) else $error("port 4 not steered by bit 4");
    a_renum_off_ident: assert property (CE && !st.renum |=> PORT1_LOGICAL == 4'h1 && PORT2_LOGICAL == 4'h2) else $error("map applied while renumbering off");
    a_port2_disable: assert property (CE && st.renum && st.remap[7:4] == 4'h0 |=> !PORT2_ENABLED) else $error("port 2 not disabled by 0000");
    a_port2_mapped: assert property (CE && st.renum && st.remap[7:4] inside {[4'h1:4'h7]} |=> PORT2_LOGICAL == $past(st.remap[7:4]) && PORT2_ENABLED) else $error("port 2 not mapped");
    a_reserved_code: assert property (CE && st.renum && st.remap[7] |=> PORT2_LOGICAL == 4'h0) else $error("reserved code not treated as 0000");
    a_port1_field: assert property (CE && st.renum && st.remap[3:0] == 4'h1 |=> PORT1_LOGICAL == 4'h1 ##0 PORT1_ENABLED) else $error("port 1 field wrong");
    a_write_answer: assert property (s_wr_taken |=> s_bresp_up) else $error("no write response after handshake");
endmodule : hpsr_top
